// ### design/jmip_defines.vh
/*
 * Constants for the link format and lane alignment parameter block:
 * register offsets, field positions, reset values and fixed ILAS values.
 * Assumes inclusion by bare name from design files under design/.
 */
`ifndef JMIP_DEFINES_VH
`define JMIP_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define JMIP_ADDR_FORMAT 12'h000
`define JMIP_ADDR_KM1 12'h004
`define JMIP_ADDR_DID 12'h008
`define JMIP_ADDR_CTRL 12'h00c
`define JMIP_ADDR_STATUS 12'h010
`define JMIP_ADDR_ILAS_SEL 12'h014
`define JMIP_ADDR_ILAS_DATA 12'h018

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define JMIP_CTRL_LINK_EN 0
`define JMIP_CTRL_SCR_EN 1
`define JMIP_ST_LANES_LSB 0
`define JMIP_ST_SPF_LSB 8
`define JMIP_ST_RQ2_LSB 16
`define JMIP_ST_SINGLE 24
`define JMIP_ST_LINK_EN 25

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define JMIP_RST_FORMAT 5'h04
`define JMIP_RST_KM1 5'h1f
`define JMIP_RST_DID 8'h00
`define JMIP_RST_SCR 1'b0

////////////////////////////////////////////////////////////////////////////////
// Format codes and multiframe length limits
`define JMIP_FMT_S4 5'h04
`define JMIP_FMT_S8 5'h05
`define JMIP_FMT_D4 5'h06
`define JMIP_FMT_D8 5'h07
`define JMIP_FMT_S16 5'h11
`define JMIP_FMT_D16 5'h12
`define JMIP_KM1_MIN 5'h11
`define JMIP_KM1_MAX 5'h1f

////////////////////////////////////////////////////////////////////////////////
// Fixed alignment parameter values, alignment octet count and lanes per link
`define JMIP_ZERO_FIELD 8'h00
`define JMIP_JESDV 3'h1
`define JMIP_SUBCLASSV 3'h1
`define JMIP_N_M1 5'h07
`define JMIP_NP_M1 5'h07
`define JMIP_F_M1 8'h00
`define JMIP_M_M1 8'h00
`define JMIP_ILAS_OCTETS 4'he
`define JMIP_LANES_PER_LINK 8

`endif

// ### design/jmip_ilas_octet.v
/*
 * Builds one octet of the lane alignment parameter set for one lane.
 * Assumes the caller supplies stable parameters and registers the result.
 */
`timescale 1ns/1ns
`default_nettype none
`include "jmip_defines.vh"

module jmip_ilas_octet (
   input wire [7:0] did_in, // Effective device id of the lane's link
   input wire [2:0] lid_in, // Lane id within the link
   input wire scr_in, // Scrambler enable
   input wire [4:0] l_m1_in, // Lanes per link minus one
   input wire [4:0] k_m1_in, // Frames per multiframe minus one
   input wire [4:0] s_m1_in, // Samples per frame minus one
   input wire [3:0] idx_in, // Octet index 0..13
   output reg [7:0] octet_out // Selected octet
);

   wire [7:0] sum;

   // Sum of field values as encoded, constant fields add zero, one or seven
   assign sum = did_in + {5'h00, lid_in} + {7'h00, scr_in} + {3'h0, l_m1_in}
      + `JMIP_F_M1 + {3'h0, k_m1_in} + `JMIP_M_M1 + {3'h0, `JMIP_N_M1}
      + {5'h00, `JMIP_SUBCLASSV} + {3'h0, `JMIP_NP_M1} + {5'h00, `JMIP_JESDV}
      + {3'h0, s_m1_in};

   always @* begin
      case (idx_in)
         4'h0: octet_out = did_in;
         4'h1: octet_out = `JMIP_ZERO_FIELD;
         4'h2: octet_out = {5'h00, lid_in};
         4'h3: octet_out = {scr_in, 2'h0, l_m1_in};
         4'h4: octet_out = `JMIP_F_M1;
         4'h5: octet_out = {3'h0, k_m1_in};
         4'h6: octet_out = `JMIP_M_M1;
         4'h7: octet_out = {3'h0, `JMIP_N_M1};
         4'h8: octet_out = {`JMIP_SUBCLASSV, `JMIP_NP_M1};
         4'h9: octet_out = {`JMIP_JESDV, s_m1_in};
         4'hd: octet_out = sum;
         default: octet_out = `JMIP_ZERO_FIELD;
      endcase
   end

endmodule // jmip_ilas_octet
`default_nettype wire

// ### design/jmip_link_cfg.v
/*
 * Link format and lane alignment parameter block of a dual-link serial
 * transmitter: APB registers, format decode, lane map, ILAS octet port.
 * Assumes APB master on clk_in; the link layer reads ILAS octets per lane.
 */
// The APB slave port and the register addresses were chosen for this implementation.
// Contract
// - Fixed ILAS fields: adjust, bank, CF, HD, reserved zero; revision, subclass one.
// - Control bits per sample reported as zero.
// - Checksum is sum of other fields modulo 256.
// - Scrambler enable comes from writable link control register.
// - Link A uses programmed device id, link B uses it plus one.
// - Lane id equals lane index 0..7 within each link.
// - Frames per multiframe 18 to 32 in steps of 2.
// - Only listed formats; codes 0-3 and 8-16 reserved.
// - Format 4: single channel, 2 lanes, S=2, R=5.
// - Format 5: single channel, 4 lanes, S=4, R=2.5.
// - Format 6: dual channel, 2 lanes, S=2, R=5.
// - Format 7: dual channel, 4 lanes, S=4, R=2.5.
// - Format 17: single channel, 8 lanes, S=8, R=1.25.
// - Format 18: dual channel, 8 lanes, S=8, R=1.25.
// - Sixteen lanes form two links of eight, A and B.
// - Only lowest lanes of each link driven; the rest powered down.
// - Bits per lane per clock sets serializer PLL multiplier.
`timescale 1ns/1ns
`default_nettype none
`include "jmip_defines.vh"

module jmip_link_cfg (
   input wire clk_in, // Device clock, 250 MHz
   input wire reset_n_in, // Asynchronous reset, active low
   input wire psel_in, // APB select
   input wire penable_in, // APB enable
   input wire pwrite_in, // APB direction, high for write
   input wire [11:0] paddr_in, // APB byte address
   input wire [31:0] pwdata_in, // APB write data
   input wire [3:0] pstrb_in, // APB byte strobes
   output wire pready_out, // APB ready, always high
   output reg [31:0] prdata_out, // APB read data
   output reg pslverr_out, // APB error
   input wire [3:0] ilas_lane_in, // Lane 0..15, bit 3 picks link B
   input wire [3:0] ilas_idx_in, // ILAS octet index 0..13
   output reg [7:0] ilas_octet_out, // ILAS octet, one cycle later
   output reg link_enable_out, // Link enable from control register
   output reg scrambler_en_out, // Scrambler enable
   output reg single_channel_out, // High for interleaved single channel
   output reg [3:0] lanes_per_link_out, // Lanes used per link
   output reg [3:0] samples_per_frame_out, // Samples per frame
   output reg [5:0] frames_per_mf_out, // Frames per multiframe
   output reg [7:0] did_a_out, // Device id on link A
   output reg [7:0] did_b_out, // Device id on link B
   output reg [4:0] serdes_mult_q2_out, // Bits per lane per clock, times 4
   output reg [15:0] lane_power_down_out // Per lane power down, bit 8+ link B
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function fmt_valid;
      input [4:0] f;
      begin
         case (f)
            `JMIP_FMT_S4, `JMIP_FMT_S8, `JMIP_FMT_D4, `JMIP_FMT_D8,
            `JMIP_FMT_S16, `JMIP_FMT_D16: fmt_valid = 1'b1;
            default: fmt_valid = 1'b0;
         endcase
      end
   endfunction

   // Lanes per link, minus one, for a valid format
   function [4:0] fmt_l_m1;
      input [4:0] f;
      begin
         case (f)
            `JMIP_FMT_S4, `JMIP_FMT_D4: fmt_l_m1 = 5'h01;
            `JMIP_FMT_S8, `JMIP_FMT_D8: fmt_l_m1 = 5'h03;
            `JMIP_FMT_S16, `JMIP_FMT_D16: fmt_l_m1 = 5'h07;
            default: fmt_l_m1 = 5'h01;
         endcase
      end
   endfunction

   // Count back to minus-one form; zero while the outputs still sit in reset
   function [4:0] count_m1;
      input [3:0] n;
      begin
         count_m1 = (n == 4'h0) ? 5'h00 : {1'b0, n - 4'h1};
      end
   endfunction

   // Link B carries the programmed id plus one, wrapping at 256
   function [7:0] link_did;
      input [7:0] d;
      input link_b;
      begin
         link_did = link_b ? d + 8'h01 : d;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg [4:0] format_reg;
   reg [4:0] km1_reg;
   reg [7:0] did_reg;
   reg scr_reg;
   reg link_en_reg;
   reg [3:0] sel_lane_reg;
   reg [3:0] sel_idx_reg;

   wire access;
   wire wr;
   wire rd;
   wire mapped;
   wire locked;
   wire cfg_addr;
   wire bad_value;
   wire [7:0] sw_octet;
   wire [7:0] port_octet;
   wire [4:0] l_m1;
   wire [4:0] s_m1;
   reg [31:0] status;
   reg [31:0] rd_word;

   assign access = psel_in & penable_in;
   assign wr = access & pwrite_in;
   // Read data captured at the end of setup, so it leaves a flip-flop
   assign rd = psel_in & ~penable_in & ~pwrite_in;
   assign pready_out = 1'b1;

   assign mapped = (paddr_in == `JMIP_ADDR_FORMAT) | (paddr_in == `JMIP_ADDR_KM1)
      | (paddr_in == `JMIP_ADDR_DID) | (paddr_in == `JMIP_ADDR_CTRL)
      | (paddr_in == `JMIP_ADDR_STATUS) | (paddr_in == `JMIP_ADDR_ILAS_SEL)
      | (paddr_in == `JMIP_ADDR_ILAS_DATA);

   // Link parameters must not move under a running link
   assign cfg_addr = (paddr_in == `JMIP_ADDR_FORMAT) | (paddr_in == `JMIP_ADDR_KM1)
      | (paddr_in == `JMIP_ADDR_DID);
   assign locked = link_en_reg & cfg_addr;

   // Reserved formats and odd or out of range frame counts are refused
   assign bad_value = ((paddr_in == `JMIP_ADDR_FORMAT) & ~fmt_valid(pwdata_in[4:0]))
      | ((paddr_in == `JMIP_ADDR_KM1) & (~pwdata_in[0]
      | (pwdata_in[4:0] < `JMIP_KM1_MIN)));

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         format_reg <= `JMIP_RST_FORMAT;
         km1_reg <= `JMIP_RST_KM1;
         did_reg <= `JMIP_RST_DID;
         scr_reg <= `JMIP_RST_SCR;
         link_en_reg <= 1'b0;
         sel_lane_reg <= 4'h0;
         sel_idx_reg <= 4'h0;
      end else if (wr & pstrb_in[0] & ~locked & ~bad_value) begin
         case (paddr_in)
            `JMIP_ADDR_FORMAT: format_reg <= pwdata_in[4:0];
            `JMIP_ADDR_KM1: km1_reg <= pwdata_in[4:0];
            `JMIP_ADDR_DID: did_reg <= pwdata_in[7:0];
            `JMIP_ADDR_CTRL: begin
               link_en_reg <= pwdata_in[`JMIP_CTRL_LINK_EN];
               scr_reg <= pwdata_in[`JMIP_CTRL_SCR_EN];
            end
            `JMIP_ADDR_ILAS_SEL: begin
               sel_lane_reg <= pwdata_in[3:0];
               sel_idx_reg <= pwdata_in[11:8];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Format decode

   assign l_m1 = fmt_l_m1(format_reg);
   // One octet per frame, so samples per frame equals lanes per link
   assign s_m1 = l_m1;

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         link_enable_out <= 1'b0;
         scrambler_en_out <= 1'b0;
         single_channel_out <= 1'b0;
         lanes_per_link_out <= 4'h0;
         samples_per_frame_out <= 4'h0;
         frames_per_mf_out <= 6'h00;
         did_a_out <= 8'h00;
         did_b_out <= 8'h00;
         serdes_mult_q2_out <= 5'h00;
         lane_power_down_out <= 16'hffff;
      end else begin
         link_enable_out <= link_en_reg;
         scrambler_en_out <= scr_reg;
         single_channel_out <= (format_reg == `JMIP_FMT_S4)
            | (format_reg == `JMIP_FMT_S8) | (format_reg == `JMIP_FMT_S16);
         lanes_per_link_out <= l_m1[3:0] + 4'h1;
         samples_per_frame_out <= s_m1[3:0] + 4'h1;
         frames_per_mf_out <= {1'b0, km1_reg} + 6'h01;
         did_a_out <= did_reg;
         did_b_out <= link_did(did_reg, 1'b1);
         case (l_m1)
            5'h01: serdes_mult_q2_out <= 5'h14;
            5'h03: serdes_mult_q2_out <= 5'h0a;
            default: serdes_mult_q2_out <= 5'h05;
         endcase
         // Each link powers down lanes above its used count
         lane_power_down_out <= {~lane_mask(l_m1), ~lane_mask(l_m1)};
      end
   end

   function [7:0] lane_mask;
      input [4:0] lm1;
      integer i;
      begin
         lane_mask = 8'h00;
         for (i = 0; i < `JMIP_LANES_PER_LINK; i = i + 1)
            lane_mask[i] = (i <= lm1);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Alignment octets: link port and software view share one builder each

   jmip_ilas_octet u_port_octet (
      .did_in(ilas_lane_in[3] ? did_b_out : did_a_out),
      .lid_in(ilas_lane_in[2:0]),
      .scr_in(scrambler_en_out),
      .l_m1_in(count_m1(lanes_per_link_out)),
      .k_m1_in(km1_reg),
      .s_m1_in(count_m1(samples_per_frame_out)),
      .idx_in(ilas_idx_in),
      .octet_out(port_octet)
   );

   jmip_ilas_octet u_sw_octet (
      .did_in(link_did(did_reg, sel_lane_reg[3])),
      .lid_in(sel_lane_reg[2:0]),
      .scr_in(scr_reg),
      .l_m1_in(l_m1),
      .k_m1_in(km1_reg),
      .s_m1_in(s_m1),
      .idx_in(sel_idx_reg),
      .octet_out(sw_octet)
   );

   // Indices past the end read as zero, so an overlong request is harmless
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         ilas_octet_out <= 8'h00;
      else if (ilas_idx_in < `JMIP_ILAS_OCTETS)
         ilas_octet_out <= port_octet;
      else
         ilas_octet_out <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path and errors, zero wait states

   always @* begin
      status = 32'h00000000;
      status[`JMIP_ST_LANES_LSB +: 4] = lanes_per_link_out;
      status[`JMIP_ST_SPF_LSB +: 4] = samples_per_frame_out;
      status[`JMIP_ST_RQ2_LSB +: 5] = serdes_mult_q2_out;
      status[`JMIP_ST_SINGLE] = single_channel_out;
      status[`JMIP_ST_LINK_EN] = link_enable_out;
   end

   always @* begin
      rd_word = 32'h00000000;
      case (paddr_in)
         `JMIP_ADDR_FORMAT: rd_word = {27'h0000000, format_reg};
         `JMIP_ADDR_KM1: rd_word = {27'h0000000, km1_reg};
         `JMIP_ADDR_DID: rd_word = {24'h000000, did_reg};
         `JMIP_ADDR_CTRL: rd_word = {30'h00000000, scr_reg, link_en_reg};
         `JMIP_ADDR_STATUS: rd_word = status;
         `JMIP_ADDR_ILAS_SEL: rd_word = {20'h00000, sel_idx_reg, 4'h0, sel_lane_reg};
         `JMIP_ADDR_ILAS_DATA: rd_word = {24'h000000,
            (sel_idx_reg < `JMIP_ILAS_OCTETS) ? sw_octet : 8'h00};
         default: rd_word = 32'h00000000;
      endcase
   end

   // Valid through the access cycle only, zero at all other times
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         prdata_out <= 32'h00000000;
      else if (rd)
         prdata_out <= rd_word;
      else
         prdata_out <= 32'h00000000;
   end

   // A refused write changes nothing and raises the one error bit; an otherwise legal write with pstrb_in[0] low is dropped with no error
   always @* begin
      pslverr_out = 1'b0;
      if (access) begin
         if (!mapped)
            pslverr_out = 1'b1;
         else if (pwrite_in & (locked | bad_value
            | (paddr_in == `JMIP_ADDR_STATUS) | (paddr_in == `JMIP_ADDR_ILAS_DATA)))
            pslverr_out = 1'b1;
      end
   end

endmodule // jmip_link_cfg
`default_nettype wire

// ### testbench/jmip_link_cfg_props.sv
/*
 * Port checker of jmip_link_cfg, attached to every instance by bind.
 * Assumes one clock domain and the register and octet timing of the design.
 */
`timescale 1ns/1ns
`default_nettype none

module jmip_link_cfg_props (
   input wire logic clk_in, // Device clock
   input wire logic reset_n_in, // Reset, active low
   input wire logic psel_in, penable_in, pwrite_in, // APB control
   input wire logic [11:0] paddr_in, // APB address
   input wire logic [31:0] pwdata_in, // APB write data
   input wire logic [3:0] pstrb_in, ilas_lane_in, ilas_idx_in, // Strobes, octet request
   input wire logic pslverr_out, scrambler_en_out, // Error, scrambler
   input wire logic [7:0] ilas_octet_out, did_a_out, did_b_out, // Octet, ids
   input wire logic [3:0] lanes_per_link_out, samples_per_frame_out, // L and S
   input wire logic [5:0] frames_per_mf_out, // K
   input wire logic [4:0] serdes_mult_q2_out, // Bits per lane times four
   input wire logic [15:0] lane_power_down_out // Lane power down
);
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   wire logic wr_acc = psel_in & penable_in & pwrite_in & pstrb_in[0];
   wire logic fmt_ok = pwdata_in[4:0] inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h11, 5'h12};
////////////////////////////////////////////////////////////////////////////////
   AST_FMT_RES: assert property (wr_acc && paddr_in == 12'h000 && !fmt_ok |-> pslverr_out)
      else $error("reserved format accepted");
   AST_K_RES: assert property (wr_acc && paddr_in == 12'h004 && (!pwdata_in[0] ||
      pwdata_in[4:0] < 5'h11) |-> pslverr_out) else $error("illegal K accepted");
   AST_K_RANGE: assert property ($past(reset_n_in) |-> !frames_per_mf_out[0] &&
      frames_per_mf_out inside {[6'h12:6'h20]}) else $error("K out of range");
   AST_DID_B: assert property ($past(reset_n_in) |-> did_b_out == did_a_out + 8'h01)
      else $error("link B id wrong");
   AST_POWER: assert property ($past(reset_n_in) |->
      lane_power_down_out == {2{8'hff << lanes_per_link_out}}) else $error("power down wrong");
   AST_RATE: assert property ($past(reset_n_in) |-> serdes_mult_q2_out * lanes_per_link_out
      == 40 && samples_per_frame_out == lanes_per_link_out) else $error("rate wrong");
   AST_SCR: assert property (wr_acc && paddr_in == 12'h00c |-> ##2
      scrambler_en_out == $past(pwdata_in[1], 2)) else $error("scrambler not taken");
   AST_LID: assert property (ilas_idx_in == 4'h2 |=>
      ilas_octet_out == {5'h00, $past(ilas_lane_in[2:0])}) else $error("lane id wrong");
   AST_DID_OCT: assert property (ilas_idx_in == 4'h0 |=> ilas_octet_out ==
      ($past(ilas_lane_in[3]) ? $past(did_b_out) : $past(did_a_out))) else $error("id octet");
   AST_FIXED: assert property (ilas_idx_in inside {4'h1, 4'h4, 4'h6, 4'ha, 4'hb, 4'hc}
      |=> ilas_octet_out == 8'h00) else $error("fixed zero octet");
   AST_VER: assert property (ilas_idx_in == 4'h8 |=> ilas_octet_out == 8'h27)
      else $error("subclass octet");
   AST_CS: assert property (ilas_idx_in == 4'h7 |=> ilas_octet_out == 8'h07)
      else $error("control bits octet");
   AST_JESDV: assert property (ilas_idx_in == 4'h9 |=> ilas_octet_out ==
      8'h1f + {4'h0, $past(samples_per_frame_out)}) else $error("revision octet");
   cover property (wr_acc && paddr_in == 12'h000 && fmt_ok);
   cover property (lanes_per_link_out == 4'h8);
   cover property (ilas_idx_in == 4'hd && ilas_lane_in[3]);
endmodule // jmip_link_cfg_props

bind jmip_link_cfg jmip_link_cfg_props props_u (.clk_in, .reset_n_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .ilas_lane_in, .ilas_idx_in, .pslverr_out,
   .scrambler_en_out, .ilas_octet_out, .did_a_out, .did_b_out, .lanes_per_link_out,
   .samples_per_frame_out, .frames_per_mf_out, .serdes_mult_q2_out, .lane_power_down_out);
`default_nettype wire

// ### testbench/jmip_link_cfg_tb.sv
/*
 * Self-checking bench of jmip_link_cfg: APB master, reference model, receiver.
 * Assumes the receiver model and the bound checker are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module jmip_link_cfg_tb;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, slow = 1'b0;
   logic pready, perr, done, cks_bad, link_en, scr_en, single, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf, lane = 4'h0, ilane, iidx, lanes, spf;
   logic [7:0] oct, dida, didb, e8;
   logic [7:0] roct [14];
   logic [7:0] exp_q [$];
   logic [5:0] kf;
   logic [4:0] mult;
   logic [15:0] pd;
   int i, j, l, t, seed = 67954, fmt = 4, km1 = 31, did = 0, scr = 0, len = 0;
   int n_fail = 0, cmp_count = 0;

   jmip_link_cfg dut_u (.clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .pready_out(pready), .prdata_out(prdata), .pslverr_out(perr), .ilas_lane_in(ilane),
      .ilas_idx_in(iidx), .ilas_octet_out(oct), .link_enable_out(link_en),
      .scrambler_en_out(scr_en), .single_channel_out(single), .lanes_per_link_out(lanes),
      .samples_per_frame_out(spf), .frames_per_mf_out(kf), .did_a_out(dida),
      .did_b_out(didb), .serdes_mult_q2_out(mult), .lane_power_down_out(pd));
   jmip_rx_model rx_u (.clk_in(clk), .go_in(go), .slow_in(slow), .lane_in(lane),
      .ilas_octet_in(oct), .ilas_lane_out(ilane), .ilas_idx_out(iidx), .done_out(done),
      .cks_bad_out(cks_bad), .oct_out(roct));

   initial forever #2 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
   function automatic int nl(int f);
      return (f == 4 || f == 6) ? 2 : (f == 5 || f == 7) ? 4 : (f == 17 || f == 18) ? 8 : 0;
   endfunction
   function automatic logic [7:0] exp_oct(int ln, int x);
      int d, v[14];
      d = (did + ln / 8) % 256;
      v = '{d, 0, ln % 8, scr * 128 + nl(fmt) - 1, 0, km1, 0, 7, 39, 31 + nl(fmt), 0, 0, 0, 0};
      v[13] = (d + ln % 8 + scr + 2 * nl(fmt) + km1 + 14) % 256;
      return v[x][7:0];
   endfunction
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      t = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         test_done;
      end
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task chk_out;
      `CHK(lanes, 4'(nl(fmt)))
      `CHK(spf, 4'(nl(fmt)))
      `CHK(single, (fmt == 4 || fmt == 5 || fmt == 17))
      `CHK(mult, 5'(40 / nl(fmt)))
      `CHK(pd, {2{8'hff << nl(fmt)}})
      `CHK(kf, 6'(km1 + 1))
      `CHK(dida, 8'(did))
      `CHK(didb, 8'(did + 1))
      `CHK(scr_en, scr[0])
      `CHK(link_en, len[0])
   endtask
   task automatic rx(int ln);
      lane <= ln[3:0];
      slow <= 1'($random(seed));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (done !== 1'b1 && t < 100);
      if (done !== 1'b1) begin
         n_fail++;
         test_done;
      end
      `CHK(cks_bad, 1'b0)
      for (j = 0; j < 14; j++) exp_q.push_back(exp_oct(ln, j));
      for (j = 0; j < 14; j++) begin
         e8 = exp_q.pop_front();
         `CHK(roct[j], e8)
      end
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk_out;
      apb(1'b0, 12'h000, 0);
      `CHK(rd, 32'h4)
      for (i = 0; i < 32; i++) begin
         apb(1'b1, 12'h000, i);
         `CHK(er, nl(i) == 0)
         if (nl(i) != 0) fmt = i;
         @(posedge clk);
         chk_out;
      end
      for (i = 31; i >= 0; i--) begin
         apb(1'b1, 12'h004, i);
         `CHK(er, i % 2 == 0 || i < 17)
         if (i % 2 == 1 && i >= 17) km1 = i;
         @(posedge clk);
         chk_out;
      end
      for (i = 0; i < 4; i++) begin
         did = i ? $random(seed) & 255 : 255;
         scr = i % 2;
         apb(1'b1, 12'h008, did);
         `CHK(er, 1'b0)
         apb(1'b1, 12'h00c, scr * 2);
         @(posedge clk);
         chk_out;
      end
      // Strobe low: write dropped silently
      pstrb <= 4'h0;
      apb(1'b1, 12'h008, 7);
      pstrb <= 4'hf;
      len = 1;
      apb(1'b1, 12'h00c, scr * 2 + 1);
      apb(1'b1, 12'h000, 4);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h010, 0);
      `CHK(rd, 32'(2 ** 25 + (40 / nl(fmt)) * 65536 + nl(fmt) * 257))
      apb(1'b1, 12'h010, 0);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h01c, 0);
      `CHK(er, 1'b1)
      @(posedge clk);
      chk_out;
      len = 0;
      apb(1'b1, 12'h00c, scr * 2);
      for (i = 0; i < 3; i++) begin
         fmt = i == 0 ? 4 : i == 1 ? 7 : 18;
         km1 = 17 + 2 * ($unsigned($random(seed)) % 8);
         apb(1'b1, 12'h000, fmt);
         apb(1'b1, 12'h004, km1);
         repeat (2) @(posedge clk);
         for (l = 0; l < 16; l++) if (l % 8 < nl(fmt)) rx(l);
         // Software view of the same octets
         for (l = 0; l < 16; l += 5) begin
            j = $unsigned($random(seed)) % 14;
            apb(1'b1, 12'h014, j * 256 + l);
            apb(1'b0, 12'h018, 0);
            `CHK(rd, 32'(exp_oct(l, j)))
         end
      end
      // Reset in mid-run: all state returns to its reset value
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(pd, 16'hffff)
      rst_n <= 1'b1;
      fmt = 4;
      km1 = 31;
      did = 0;
      scr = 0;
      repeat (2) @(posedge clk);
      chk_out;
      rx(9);
      test_done;
   end
endmodule // jmip_link_cfg_tb
`default_nettype wire

// ### testbench/jmip_rx_model.sv
/*
 * Receiver model: reads the 14 alignment octets of one lane and checks the checksum.
 * Assumes octets answer one edge after the request is sampled.
 */
`timescale 1ns/1ns
`default_nettype none

module jmip_rx_model (
   input wire logic clk_in, // Device clock
   input wire logic go_in, slow_in, // Start one lane, idle between reads
   input wire logic [3:0] lane_in, // Lane to read
   input wire logic [7:0] ilas_octet_in, // Octet from transmitter
   output logic [3:0] ilas_lane_out, ilas_idx_out, // Octet request
   output logic done_out, cks_bad_out, // Lane read, checksum mismatch
   output logic [7:0] oct_out [14] // Octets received
);
   int i;
   logic [7:0] s;
   initial begin
      ilas_lane_out = 4'h0;
      ilas_idx_out = 4'hf;
      done_out = 1'b0;
      cks_bad_out = 1'b0;
      forever begin
         @(posedge clk_in);
         if (go_in) begin
            done_out <= 1'b0;
            for (i = 0; i < 14; i++) begin
               ilas_lane_out <= lane_in;
               ilas_idx_out <= i[3:0];
               repeat (2) @(posedge clk_in);
               oct_out[i] = ilas_octet_in;
               if (slow_in) @(posedge clk_in);
            end
            // Fields summed as values, not whole octets
            s = oct_out[0] + oct_out[1] + oct_out[2][4:0] + oct_out[3][7] + oct_out[3][4:0]
               + oct_out[4] + oct_out[5][4:0] + oct_out[6] + oct_out[7][4:0] + oct_out[8][7:5]
               + oct_out[8][4:0] + oct_out[9][7:5] + oct_out[9][4:0] + oct_out[10];
            cks_bad_out <= s !== oct_out[13];
            ilas_idx_out <= 4'hf;
            done_out <= 1'b1;
         end
      end
   end
endmodule // jmip_rx_model
`default_nettype wire
